// ===== rtl/asp_pkg.sv
// shared constants and types of the converter serial port
// assumes the master clock is clk_sys; time counts are in its cycles, frame counts in serial clock halves
package asp_pkg;

    localparam int TX_W = 32;
    localparam int RX_W = 8;
    localparam int TOUT_W = 17;
    localparam int HALF_W = 6;
    // command decode time and timeouts, in master clock cycles
    localparam int DECODE_CYC = 4;
    localparam int TOUT_LONG_EXP = 16;
    localparam int TOUT_SHORT_EXP = 14;
    localparam int TOUT_LONG_CYC = 2 ** TOUT_LONG_EXP;
    localparam int TOUT_SHORT_CYC = 2 ** TOUT_SHORT_EXP;
    // master clock cycles per half serial clock period in frame master mode
    localparam int SCLK_HALF_CYC = 4;
    localparam int DIV_W = 8;
    // a frame is 32 serial clock periods, i.e. 64 halves
    localparam logic [HALF_W-1:0] HALF_LAST = 6'h3f;
    localparam logic [HALF_W-1:0] STROBE_HIGH_HALVES = 6'h20;
    localparam logic [2:0] RX_LAST_BIT = 3'h7;
    localparam logic [2:0] DECODE_LOAD = 3'h4;

    typedef enum logic [1:0] {
        asp_idle = 2'b00,
        asp_spi = 2'b01,
        asp_frame = 2'b10
    } asp_mode_e;

endpackage

// ===== rtl/asp_serial_port.sv
// serial data port of the converter: spi slave and frame-sync master
// assumes clk_sys is the master clock; pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int TOUT_LONG = TOUT_LONG_CYC,
    parameter int TOUT_SHORT = TOUT_SHORT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic frame_master_mode,
    input wire logic timeout_length_select,
    input wire logic [TX_W-1:0] tx_word,
    output logic tx_word_take,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    input wire logic chain_serial_input,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    output logic sclk_out,
    output logic frame_strobe,
    output logic [RX_W-1:0] cmd_byte,
    output logic cmd_valid
);

    typedef struct packed {
        asp_mode_e mode;
        logic cs_d1;
        logic sclk_d1;
        logic [TX_W-1:0] tx_sr;
        logic chain_q;
        logic [RX_W-1:0] rx_sr;
        logic [2:0] rx_cnt;
        logic pend;
        logic [TOUT_W-1:0] tout_cnt;
        logic [2:0] dec_cnt;
        logic [RX_W-1:0] cmd;
        logic cmd_valid;
        logic rx_done;
        logic sdo;
        logic sdo_oe_n;
        logic sclk_o;
        logic fstrobe;
        logic [HALF_W-1:0] half;
        logic take;
    } asp_port_s;

    localparam asp_port_s ASP_RST = '{mode: asp_idle, cs_d1: 1'b1, sdo_oe_n: 1'b1, default: '0};

    asp_port_s q;
    asp_port_s n;
    logic [3:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic sdi_s;
    logic chain_s;
    logic tick;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic tout_hit;
    logic [TOUT_W-1:0] tout_lim;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and serial clock divider

    asp_sync #(.N(4), .INIT(4'h1)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din({chain_serial_input, spi_sdi, spi_sclk, spi_cs_n}),
        .dout(pins_s)
    );

    assign cs_s = pins_s[0];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[2];
    assign chain_s = pins_s[3];

    asp_tick_div #(.HALF(SCLK_HALF_CYC)) u_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .run(q.mode == asp_frame),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // edge detection and timeout limit

    assign cs_fall = q.cs_d1 & ~cs_s;
    assign sclk_rise = ~q.sclk_d1 & sclk_s;
    assign sclk_fall = q.sclk_d1 & ~sclk_s;
    assign tout_lim = timeout_length_select ? TOUT_W'(TOUT_SHORT) : TOUT_W'(TOUT_LONG);
    assign tout_hit = q.pend && (q.tout_cnt == tout_lim - TOUT_W'(1));

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = q;
        n.cmd_valid = 1'b0;
        n.rx_done = 1'b0;
        n.take = 1'b0;
        n.cs_d1 = cs_s;
        n.sclk_d1 = sclk_s;
        // decode delay runs independently of the shifting
        if (q.dec_cnt != 3'h0) begin
            n.dec_cnt = q.dec_cnt - 3'h1;
            n.cmd_valid = (q.dec_cnt == 3'h1);
        end
        case (q.mode)
            asp_idle: begin
                n.sdo_oe_n = 1'b1;
                n.sdo = 1'b0;
                n.sclk_o = 1'b0;
                n.fstrobe = 1'b0;
                n.pend = 1'b0;
                n.rx_cnt = 3'h0;
                n.tout_cnt = '0;
                if (frame_master_mode) begin
                    n.mode = asp_frame;
                    n.half = HALF_LAST;
                    n.sdo_oe_n = 1'b0;
                end else begin
                    n.mode = asp_spi;
                    // select already low covers a select tied low permanently
                    if (!cs_s) begin
                        n.tx_sr = tx_word;
                        n.sdo = tx_word[TX_W-1];
                        n.sdo_oe_n = 1'b0;
                        n.take = 1'b1;
                    end
                end
            end
            asp_spi: begin
                if (frame_master_mode) begin
                    n.mode = asp_idle;
                end else if (cs_s) begin
                    n.sdo_oe_n = 1'b1;
                    n.pend = 1'b0;
                    n.rx_cnt = 3'h0;
                    n.tout_cnt = '0;
                end else if (cs_fall || tout_hit) begin
                    // a timeout also reframes the output word when select stays low
                    n.sdo_oe_n = 1'b0;
                    n.tx_sr = tx_word;
                    n.sdo = tx_word[TX_W-1];
                    n.take = 1'b1;
                    n.pend = 1'b0;
                    n.rx_cnt = 3'h0;
                    n.tout_cnt = '0;
                end else begin
                    if (sclk_rise) begin
                        n.sdo = q.tx_sr[TX_W-1];
                        n.tx_sr = {q.tx_sr[TX_W-2:0], q.chain_q};
                    end
                    if (sclk_fall) begin
                        n.chain_q = chain_s;
                        n.rx_sr = {q.rx_sr[RX_W-2:0], sdi_s};
                        n.rx_cnt = q.rx_cnt + 3'h1;
                        if (q.rx_cnt == RX_LAST_BIT) begin
                            n.rx_done = 1'b1;
                            n.cmd = {q.rx_sr[RX_W-2:0], sdi_s};
                            n.dec_cnt = DECODE_LOAD;
                        end
                    end
                    if (sclk_rise || sclk_fall) begin
                        n.tout_cnt = '0;
                        n.pend = !(sclk_fall && q.rx_cnt == RX_LAST_BIT);
                    end else if (q.pend) begin
                        n.tout_cnt = q.tout_cnt + TOUT_W'(1);
                    end
                end
            end
            asp_frame: begin
                if (!frame_master_mode) begin
                    n.mode = asp_idle;
                end else if (tick) begin
                    // clock toggles from a flop on the master clock edge
                    n.half = q.half + 6'h01;
                    n.sclk_o = n.half[0];
                    n.fstrobe = n.half < STROBE_HIGH_HALVES;
                    if (n.half == 6'h00) begin
                        n.tx_sr = tx_word;
                        n.sdo = tx_word[TX_W-1];
                        n.take = 1'b1;
                    end else if (!n.half[0]) begin
                        n.sdo = q.tx_sr[TX_W-2];
                        n.tx_sr = {q.tx_sr[TX_W-2:0], 1'b0};
                    end
                end
            end
            default: begin
                n.mode = asp_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= ASP_RST;
        end else begin
            q <= n;
        end
    end

    assign spi_sdo = q.sdo;
    assign spi_sdo_oe_n = q.sdo_oe_n;
    assign sclk_out = q.sclk_o;
    assign frame_strobe = q.fstrobe;
    assign cmd_byte = q.cmd;
    assign cmd_valid = q.cmd_valid;
    assign tx_word_take = q.take;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    logic spi_on;
    logic frm_on;
    assign spi_on = (q.mode == asp_spi) && !frame_master_mode;
    assign frm_on = (q.mode == asp_frame) && frame_master_mode;

    a_sclk_idle_low: assert property (q.mode != asp_frame |=> !sclk_out)
        else $error("serial clock not low outside frame mode");
    a_tout_restart: assert property (spi_on && !cs_s && tout_hit
        |=> q.rx_cnt == 3'h0 && !q.pend)
        else $error("timeout did not restart bit count");
    a_tout_limit: assert property (q.pend |-> q.tout_cnt < tout_lim)
        else $error("timeout counter passed its limit");
    a_decode_time: assert property (q.rx_done |-> ##4 cmd_valid)
        else $error("command not presented four cycles after last bit");
    a_oe_release: assert property (spi_on && cs_s |=> spi_sdo_oe_n)
        else $error("output still driven with select high");
    a_oe_drive: assert property (spi_on && cs_fall |=> !spi_sdo_oe_n && tx_word_take)
        else $error("output not driven after select fall");
    a_sdo_rise: assert property (spi_on && !cs_s && !tout_hit && !cs_fall && sclk_rise
        |=> spi_sdo == $past(q.tx_sr[TX_W-1]))
        else $error("output did not take next bit on rising clock");
    a_sdi_fall: assert property (spi_on && !cs_s && !tout_hit && !cs_fall && sclk_fall
        |=> q.rx_sr[0] == $past(sdi_s) && q.chain_q == $past(chain_s))
        else $error("input not sampled on falling clock");
    a_chain_shift: assert property (spi_on && !cs_s && !tout_hit && !cs_fall
        && sclk_rise |=> q.tx_sr[0] == $past(q.chain_q))
        else $error("chain bit not shifted through");
    a_strobe_rise: assert property (frm_on && $rose(frame_strobe) |-> q.half == 6'h00)
        else $error("strobe rose away from frame start");
    a_strobe_fall: assert property (frm_on && $fell(frame_strobe)
        |-> q.half == STROBE_HIGH_HALVES)
        else $error("strobe fell away from half frame");
    a_sclk_on_tick: assert property (frm_on && $changed(sclk_out) |-> $past(tick))
        else $error("serial clock changed off the divider tick");
    a_sclk_fall_even: assert property (frm_on && $fell(sclk_out) |-> !q.half[0])
        else $error("serial clock fell on a high half");
    a_msb_at_strobe: assert property (frm_on && $rose(frame_strobe)
        |-> spi_sdo == $past(tx_word[TX_W-1]))
        else $error("msb not placed at strobe rise");
    // the pass through idle clears the output once, so only steady frame cycles are watched
    a_sdo_on_fall: assert property (frm_on && $past(q.mode) == asp_frame && $changed(spi_sdo)
        |-> $fell(sclk_out) || q.half == 6'h00)
        else $error("output changed away from falling clock");

    // word loading, strobe and counter housekeeping
    a_take_single: assert property (tx_word_take |=> !tx_word_take)
        else $error("word take lasted more than one cycle");
    a_take_at_frame: assert property (frm_on && $rose(frame_strobe) |-> tx_word_take)
        else $error("word not taken at frame start");
    a_strobe_outside: assert property (q.mode != asp_frame |=> !frame_strobe)
        else $error("strobe high outside frame mode");
    a_oe_in_frame: assert property (frm_on |-> !spi_sdo_oe_n)
        else $error("output not driven in frame mode");
    a_tout_idle_zero: assert property (spi_on && !q.pend |-> q.tout_cnt == '0)
        else $error("timeout counter running with nothing pending");
    a_byte_wrap: assert property (q.rx_done |-> q.rx_cnt == 3'h0)
        else $error("bit count not back to zero after a byte");
    a_cmd_hold: assert property (!q.rx_done |-> $stable(cmd_byte))
        else $error("command byte changed without a new byte");

    // main scenarios
    c_spi_cmd: cover property (spi_on && cmd_valid);
    c_timeout: cover property (spi_on && tout_hit);
    c_frame_start: cover property (frm_on && $rose(frame_strobe));
    c_chain_word: cover property (spi_on && sclk_rise && q.chain_q);
    c_strobe_fall: cover property (frm_on && $fell(frame_strobe));

endmodule
`default_nettype wire

// ===== rtl/asp_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes every bit is an independent level from outside clk_sys
`timescale 1ns/1ps
`default_nettype none
module asp_sync
    import asp_pkg::*;
#(
    parameter int N = 4,
    parameter logic [N-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [N-1:0] din,
    output logic [N-1:0] dout
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
    } asp_sync_s;

    asp_sync_s q;
    asp_sync_s d;

    // first stage feeds only the second stage
    always_comb begin
        d = q;
        for (int i = 0; i < N; i++) begin
            d.s1[i] = din[i];
            d.s2[i] = q.s1[i];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '{s1: INIT, s2: INIT};
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;

endmodule
`default_nettype wire

// ===== rtl/asp_tick_div.sv
// divider giving a one-cycle enable every HALF master clock cycles
// assumes run is a level from clk_sys logic; count restarts when run drops
`timescale 1ns/1ps
`default_nettype none
module asp_tick_div
    import asp_pkg::*;
#(
    parameter int HALF = SCLK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic run,
    output logic tick
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } asp_div_s;

    asp_div_s q;
    asp_div_s d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = '0;
        end else if (q.cnt == DIV_W'(HALF - 1)) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule
`default_nettype wire

// ===== verif/adc_serial_port_framing_test.sv
// self-checking bench of the converter serial port, spi and frame master
// assumes short timeouts of 64 and 16 clocks so idle gaps stay brief
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port_framing_test;
    import asp_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic frame_master_mode = 1'b0;
    logic timeout_length_select = 1'b0;
    logic [TX_W-1:0] tx_word = '0;
    logic tx_word_take, spi_cs_n, spi_sclk, spi_sdi, chain_serial_input;
    logic spi_sdo, spi_sdo_oe_n, sclk_out, frame_strobe, cmd_valid;
    logic [RX_W-1:0] cmd_byte;
    logic [7:0] cmdq[$];
    int seed = 32'h36975cc2;
    int miscompares = 0;
    int samples_checked = 0;
    int takes = 0;

    always #5 clk_sys = ~clk_sys;

    asp_serial_port #(.TOUT_LONG(64), .TOUT_SHORT(16)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .frame_master_mode(frame_master_mode),
        .timeout_length_select(timeout_length_select), .tx_word(tx_word),
        .tx_word_take(tx_word_take), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .chain_serial_input(chain_serial_input), .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n), .sclk_out(sclk_out), .frame_strobe(frame_strobe),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid));

    asp_host_model host (
        .clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
        .chain_serial_input(chain_serial_input), .spi_sdo(spi_sdo));

    // outputs settle after the rising edge, so they are collected mid-cycle
    always @(negedge clk_sys) begin
        if (cmd_valid === 1'b1) begin
            cmdq.push_back(cmd_byte);
        end
        if (tx_word_take === 1'b1) begin
            takes++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // without a timeout the stale bits lead the next byte
    function automatic logic [7:0] exp_cmd(input logic to, input logic [2:0] p,
                                           input logic [7:0] b);
        return to ? b : {p, b[7:3]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [63:0] d, c, q;
        logic [31:0] frm;
        int n, hi, sh, rises, oe, tk, t0;
        logic prev;
        repeat (12) @(negedge clk_sys);
        chk("reset outputs", 14'h2000, {spi_sdo_oe_n, spi_sdo, sclk_out, frame_strobe,
            cmd_valid, tx_word_take, cmd_byte});
        resetn = 1'b1;
        repeat (6) @(negedge clk_sys);

        // six commands back to back, word out, chained bits behind it
        tx_word = $random(seed);
        d = {$random(seed), $random(seed)};
        c = {$random(seed), $random(seed)};
        t0 = takes;
        host.select();
        chk("oe at select", 2'b00, {spi_sdo_oe_n, spi_sdo ^ tx_word[31]});
        chk("take at select", t0 + 1, takes);
        host.xfer(48, d, c, q);
        chk("sdo word", tx_word, q[47:16]);
        chk("sdo chained", c[47:40], q[14:7]);
        repeat (12) @(negedge clk_sys);
        chk("cmd count", 6, cmdq.size());
        for (int i = 0; i < 6 && cmdq.size() > 0; i++) begin
            chk("cmd byte", d[47-8*i -: 8], cmdq.pop_front());
        end
        host.deselect();
        chk("oe released", 1'b1, spi_sdo_oe_n);
        $display("test spi frame done");

        // partial byte then a 40 clock gap: short limit drops it, long keeps it
        for (int s = 1; s >= 0; s--) begin
            timeout_length_select = s[0];
            d = {$random(seed), $random(seed)};
            t0 = takes;
            host.select();
            host.xfer(3, d[10:8], '0, q);
            repeat (40) @(negedge clk_sys);
            cmdq.delete();
            host.xfer(8, d[7:0], '0, q);
            repeat (12) @(negedge clk_sys);
            chk("cmd after gap", exp_cmd(s[0], d[10:8], d[7:0]),
                cmdq.size() ? cmdq[0] : 8'hxx);
            repeat (70) @(negedge clk_sys);
            host.deselect();
            // one load at select, one reload when the dangling bits time out
            chk("word reloads", t0 + 2, takes);
            $display("test timeout select %0d done", s);
        end

        // frame master: one whole frame after the first strobe rise
        tx_word = $random(seed);
        frame_master_mode = 1'b1;
        for (n = 0; n < 600 && frame_strobe !== 1'b1; n++) @(negedge clk_sys);
        if (n == 600) begin
            miscompares++;
            wrap_up();
        end
        hi = 0;
        sh = 0;
        rises = 0;
        oe = 0;
        tk = 0;
        frm = '0;
        prev = 1'b0;
        for (int i = 0; i < 64 * SCLK_HALF_CYC; i++) begin
            hi += (frame_strobe === 1'b1);
            sh += (sclk_out === 1'b1);
            oe += (spi_sdo_oe_n === 1'b0);
            tk += (tx_word_take === 1'b1);
            if (sclk_out === 1'b1 && prev === 1'b0) begin
                rises++;
                frm = {frm[30:0], spi_sdo};
            end
            prev = sclk_out;
            @(negedge clk_sys);
        end
        chk("strobe high", 32 * SCLK_HALF_CYC, hi);
        chk("sclk rises", 32, rises);
        chk("sclk high", 32 * SCLK_HALF_CYC, sh);
        chk("oe in frame", 64 * SCLK_HALF_CYC, oe);
        chk("take per frame", 1, tk);
        chk("frame word", tx_word, frm);
        chk("next strobe", 1'b1, frame_strobe);
        $display("test frame master done");
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== verif/asp_host_model.sv
// host serial port model: spi master toward the converter port
// assumes the bench calls its tasks; pins move only on falling clk_sys
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
    input wire logic clk_sys,
    output var logic spi_cs_n,
    output var logic spi_sclk,
    output var logic spi_sdi,
    output var logic chain_serial_input,
    input wire logic spi_sdo
);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
        chain_serial_input = 1'b0;
    end

    task automatic select();
        @(negedge clk_sys);
        spi_cs_n = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask

    // last fall was at least 16 clocks ago, then select stays high 6 clocks
    task automatic deselect();
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
        chain_serial_input = ~chain_serial_input;
        repeat (6) @(negedge clk_sys);
    endtask

    // cpha 1: data set before the rise, held past the fall; sdo read at the fall
    task automatic xfer(input int n, input logic [63:0] d, input logic [63:0] c,
                        output logic [63:0] q);
        q = '0;
        for (int i = n - 1; i >= 0; i--) begin
            spi_sdi = d[i];
            chain_serial_input = c[i];
            spi_sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            q[i] = spi_sdo;
            spi_sclk = 1'b0;
            repeat (4) @(negedge clk_sys);
        end
        spi_sdi = ~spi_sdi;
    endtask
endmodule
`default_nettype wire
